// ---- src/gain_sel_pkg.sv ----
/*
 * Constants for the gain set selector: register map, field layout,
 * setting ranges, switching modes and timing.
 * Assumes a 40 MHz reference clock and a 32-bit AHB-Lite register bus.
 */
package gain_sel_pkg;

	// timing: the delay settings count 0.1 ms ticks
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_PERIOD_NS = 100000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 12;

	// setting ranges
	localparam int SET_W = 15;
	localparam int DELAY_W = 14;
	localparam logic [SET_W-1:0] DELAY_MAX = 15'h2710;
	localparam logic [SET_W-1:0] LEVEL_MAX = 15'h4E20;
	localparam logic [SET_W-1:0] HYST_MAX = 15'h4E20;
	localparam logic [SET_W-1:0] SET_RESET = 15'h0000;

	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SET_BASE = 8'h04;
	localparam logic [ADDR_W-1:0] SET_STRIDE = 8'h0C;
	localparam logic [ADDR_W-1:0] FLD_DELAY = 8'h00;
	localparam logic [ADDR_W-1:0] FLD_LEVEL = 8'h04;
	localparam logic [ADDR_W-1:0] FLD_HYST = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_ASSIGN = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;

	// setting sets: index 0 velocity, index 1 torque
	localparam int NUM_SETS = 2;
	localparam int SET_VEL = 0;
	localparam int SET_TRQ = 1;

	// mode register fields
	localparam int MODE_VEL_LSB = 0;
	localparam int MODE_VEL_W = 3;
	localparam int MODE_TRQ_LSB = 4;
	localparam int MODE_TRQ_W = 2;
	localparam logic [MODE_VEL_W-1:0] VEL_MODE_MAX = 3'h5;
	localparam logic [MODE_VEL_W-1:0] MODE_RESET = 3'h0;

	// switching modes
	localparam logic [MODE_VEL_W-1:0] SW_FIXED_FIRST = 3'h0;
	localparam logic [MODE_VEL_W-1:0] SW_FIXED_SECOND = 3'h1;
	localparam logic [MODE_VEL_W-1:0] SW_INPUT = 3'h2;
	localparam logic [MODE_VEL_W-1:0] SW_TORQUE = 3'h3;
	localparam logic [MODE_VEL_W-1:0] SW_SPEED_VAR = 3'h4;

	// assignment and status fields
	localparam int ASSIGN_PEND_BIT = 0;
	localparam int ASSIGN_ACT_BIT = 1;
	localparam int ST_SECOND_BIT = 0;
	localparam int ST_PIN_BIT = 1;
	localparam int ST_METHOD_LSB = 2;
	localparam int ST_TIMING_BIT = 4;

	// ahb-lite
	localparam int HADDR_W = 32;
	localparam int HDATA_W = 32;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		CM_POSITION = 2'h0,
		CM_VELOCITY = 2'h1,
		CM_TORQUE = 2'h2,
		CM_FULL_CLOSED = 2'h3
	} ctrl_method_t;

	typedef enum logic {
		GS_FIRST = 1'h0,
		GS_SECOND = 1'h1
	} gain_state_t;

endpackage

// ---- src/servo_gain_set_selector.sv ----
/*
 * Gain set selector: picks first_gain_set or second_gain_set from
 * velocity/torque switching settings held in AHB-Lite registers.
 * Assumes one 40 MHz clock, commands from logic on that clock, and the
 * gain-select pin from outside, low while tied to input_common_return.
 */
// Overview of operation
// RQ1 - mode 0 always selects the first gain set.
// RQ2 - mode 1 always selects the second gain set.
// RQ3 - mode 2: pin open gives first set, pin to common return second.
// RQ4 - mode 2 with no pin assigned keeps the first set.
// RQ5 - mode 3: first to second once abs torque exceeds level plus hysteresis.
// RQ6 - mode 3: back to first after abs torque below level minus hysteresis for delay.
// RQ7 - velocity mode 4: to second once abs speed variation exceeds level plus hysteresis.
// RQ8 - velocity mode 4: back to first after variation stays low for delay.
// RQ9 - velocity mode 4 holds the first set outside velocity control.
// RQ10 - velocity delay 0 to 10000 ticks of 0.1 ms, default 0.
// RQ11 - velocity level 0 to 20000, default 0, trigger level for modes 3 to 5; the code uses it in modes 3 and 4 only, mode 5 holds the first set.
// RQ12 - velocity hysteresis 0 to 20000, default 0, used in modes 3 to 5; the code uses it in modes 3 and 4 only.
// RQ13 - hysteresis above level is treated as equal to level.
// RQ14 - torque mode 0 to 3, default 0, acting only under torque control.
// RQ15 - torque delay 0 to 10000 ticks of 0.1 ms, used in torque mode 3.
// RQ16 - torque level 0 to 20000, default 0, trigger level in torque mode 3.
// RQ17 - torque hysteresis 0 to 20000, default 0, used in torque mode 3.
// RQ18 - power-up-only settings take effect at the next control power-up.
// RQ19 - velocity mode 0 to 5, default 0, acting only under velocity control.
// RQ20 - return timer restarts when low condition breaks, returns at count.
`timescale 1ns/1ps
`default_nettype none

module servo_gain_set_selector #(
	parameter int CMD_W = 17
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [gain_sel_pkg::HADDR_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [gain_sel_pkg::HDATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	output logic [gain_sel_pkg::HDATA_W-1:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// gain-select pin, low while tied to input_common_return
	input wire logic i_gain_sel_n,
	// internal control state and commands
	input wire gain_sel_pkg::ctrl_method_t i_ctrl_method,
	input wire logic signed [CMD_W-1:0] i_torque_cmd,
	input wire logic signed [CMD_W-1:0] i_speed_cmd_var,
	input wire logic i_ctrl_power_on,
	// gain selection
	output logic o_second_gain_set
);
	import gain_sel_pkg::*;

	if (CMD_W < 2 || CMD_W > 31) begin : g_bad_cmd_w
		$error("CMD_W must lie between 2 and 31");
	end

	// package constants the logic depends on
	if (TICK_CYCLES < 2 || TICK_CYCLES > 2**TICK_CNT_W) begin : g_bad_tick
		$error("tick period does not fit the tick counter");
	end

	if (int'(DELAY_MAX) >= 2**DELAY_W) begin : g_bad_delay_w
		$error("delay ceiling does not fit the return counter");
	end

	if (int'(LEVEL_MAX) + int'(HYST_MAX) >= 2**(SET_W+1)) begin : g_bad_thr
		$error("upper threshold does not fit its width");
	end

	if (NUM_SETS != 2 || SET_VEL == SET_TRQ) begin : g_bad_sets
		$error("exactly two distinct setting sets are supported");
	end

	if (int'(ADDR_SET_BASE) + NUM_SETS * int'(SET_STRIDE) >
			int'(ADDR_ASSIGN)) begin : g_bad_map
		$error("setting registers overlap the assignment register");
	end

	if (ADDR_STATUS == ADDR_ASSIGN || ADDR_STATUS == ADDR_MODE) begin : g_bad_st
		$error("status register shares an address");
	end

	if (ST_TIMING_BIT < ST_METHOD_LSB + 2) begin : g_bad_st_fld
		$error("status fields overlap");
	end

	function automatic logic [ADDR_W-1:0] set_addr(input int s,
			input logic [ADDR_W-1:0] fld);
		set_addr = ADDR_W'(ADDR_SET_BASE + ADDR_W'(s) * SET_STRIDE + fld);
	endfunction

	function automatic logic [SET_W-1:0] fld_max(
			input logic [ADDR_W-1:0] fld);
		fld_max = (fld == FLD_DELAY) ? DELAY_MAX :
			(fld == FLD_LEVEL) ? LEVEL_MAX : HYST_MAX;
	endfunction

	// pin synchroniser
	logic gin_meta_ff, gin_sync_ff;
	logic nxt_gin_meta, nxt_gin_sync;

	always_comb begin
		nxt_gin_meta = i_gain_sel_n;
		nxt_gin_sync = gin_meta_ff;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			gin_meta_ff <= 1'h1;
			gin_sync_ff <= 1'h1;
		end else begin
			gin_meta_ff <= nxt_gin_meta;
			gin_sync_ff <= nxt_gin_sync;
		end
	end

	// bus address phase capture
	logic wr_pend_ff, nxt_wr_pend;
	logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
	logic [HDATA_W-1:0] hrdata_ff, nxt_hrdata;
	logic hready_ff, hresp_ff;
	logic ap_valid;
	logic [HDATA_W-1:0] rd_mux;

	// settings
	logic [MODE_VEL_W-1:0] vel_mode_ff, nxt_vel_mode;
	logic [MODE_TRQ_W-1:0] trq_mode_ff, nxt_trq_mode;
	logic [SET_W-1:0] delay_ff [NUM_SETS];
	logic [SET_W-1:0] level_ff [NUM_SETS];
	logic [SET_W-1:0] hyst_ff [NUM_SETS];
	logic [SET_W-1:0] nxt_delay [NUM_SETS];
	logic [SET_W-1:0] nxt_level [NUM_SETS];
	logic [SET_W-1:0] nxt_hyst [NUM_SETS];
	logic assign_pend_ff, nxt_assign_pend;
	logic assign_act_ff, nxt_assign_act;

	// switching state
	gain_state_t state_ff, nxt_state;
	logic [DELAY_W-1:0] dly_cnt_ff, nxt_dly_cnt;
	logic [TICK_CNT_W-1:0] tick_cnt_ff, nxt_tick_cnt;
	logic tick;

	always_comb begin
		ap_valid = i_hsel && i_hready && i_htrans[1] &&
			(i_haddr[HADDR_W-1:ADDR_W] == '0);
		nxt_wr_pend = ap_valid && i_hwrite;
		nxt_wr_addr = ap_valid ? i_haddr[ADDR_W-1:0] : wr_addr_ff;
		nxt_hrdata = (ap_valid && !i_hwrite) ? rd_mux : '0;
	end

	// register writes land in the data phase, out-of-range values dropped
	always_comb begin
		nxt_vel_mode = vel_mode_ff;
		nxt_trq_mode = trq_mode_ff;
		nxt_assign_pend = assign_pend_ff;
		nxt_assign_act = assign_act_ff;
		for (int s = 0; s < NUM_SETS; s++) begin
			nxt_delay[s] = delay_ff[s];
			nxt_level[s] = level_ff[s];
			nxt_hyst[s] = hyst_ff[s];
		end
		if (wr_pend_ff) begin
			if (wr_addr_ff == ADDR_MODE) begin
				if (i_hwdata[MODE_VEL_LSB +: MODE_VEL_W] <= VEL_MODE_MAX) begin
					nxt_vel_mode = i_hwdata[MODE_VEL_LSB +: MODE_VEL_W]; // see RQ19
				end
				nxt_trq_mode = i_hwdata[MODE_TRQ_LSB +: MODE_TRQ_W]; // see RQ14
			end
			if (wr_addr_ff == ADDR_ASSIGN) begin
				nxt_assign_pend = i_hwdata[ASSIGN_PEND_BIT]; // see RQ18
			end
			for (int s = 0; s < NUM_SETS; s++) begin
				// see RQ10, see RQ15
				if (wr_addr_ff == set_addr(s, FLD_DELAY) &&
						i_hwdata[HDATA_W-1:SET_W] == '0 &&
						i_hwdata[SET_W-1:0] <= fld_max(FLD_DELAY)) begin
					nxt_delay[s] = i_hwdata[SET_W-1:0];
				end
				// see RQ11, see RQ16
				if (wr_addr_ff == set_addr(s, FLD_LEVEL) &&
						i_hwdata[HDATA_W-1:SET_W] == '0 &&
						i_hwdata[SET_W-1:0] <= fld_max(FLD_LEVEL)) begin
					nxt_level[s] = i_hwdata[SET_W-1:0];
				end
				// see RQ12, see RQ17
				if (wr_addr_ff == set_addr(s, FLD_HYST) &&
						i_hwdata[HDATA_W-1:SET_W] == '0 &&
						i_hwdata[SET_W-1:0] <= fld_max(FLD_HYST)) begin
					nxt_hyst[s] = i_hwdata[SET_W-1:0];
				end
			end
		end
		// pin assignment is only taken over at control power-up
		if (i_ctrl_power_on) begin
			nxt_assign_act = nxt_assign_pend; // see RQ18
		end
	end

	// read data from next values, so a write just ahead is seen
	always_comb begin
		rd_mux = '0;
		if (i_haddr[ADDR_W-1:0] == ADDR_MODE) begin
			rd_mux[MODE_VEL_LSB +: MODE_VEL_W] = nxt_vel_mode;
			rd_mux[MODE_TRQ_LSB +: MODE_TRQ_W] = nxt_trq_mode;
		end
		if (i_haddr[ADDR_W-1:0] == ADDR_ASSIGN) begin
			rd_mux[ASSIGN_PEND_BIT] = nxt_assign_pend;
			rd_mux[ASSIGN_ACT_BIT] = nxt_assign_act;
		end
		if (i_haddr[ADDR_W-1:0] == ADDR_STATUS) begin
			rd_mux[ST_SECOND_BIT] = state_ff;
			rd_mux[ST_PIN_BIT] = gin_sync_ff;
			rd_mux[ST_METHOD_LSB +: 2] = i_ctrl_method;
			rd_mux[ST_TIMING_BIT] = (dly_cnt_ff != '0);
		end
		for (int s = 0; s < NUM_SETS; s++) begin
			if (i_haddr[ADDR_W-1:0] == set_addr(s, FLD_DELAY)) begin
				rd_mux[SET_W-1:0] = nxt_delay[s];
			end
			if (i_haddr[ADDR_W-1:0] == set_addr(s, FLD_LEVEL)) begin
				rd_mux[SET_W-1:0] = nxt_level[s];
			end
			if (i_haddr[ADDR_W-1:0] == set_addr(s, FLD_HYST)) begin
				rd_mux[SET_W-1:0] = nxt_hyst[s];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wr_pend_ff <= 1'h0;
			wr_addr_ff <= '0;
			hrdata_ff <= '0;
			hready_ff <= 1'h1;
			hresp_ff <= HRESP_OKAY;
			vel_mode_ff <= MODE_RESET;
			trq_mode_ff <= MODE_TRQ_W'(MODE_RESET);
			assign_pend_ff <= 1'h0;
			assign_act_ff <= 1'h0;
			for (int s = 0; s < NUM_SETS; s++) begin
				delay_ff[s] <= SET_RESET;
				level_ff[s] <= SET_RESET;
				hyst_ff[s] <= SET_RESET;
			end
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			hrdata_ff <= nxt_hrdata;
			hready_ff <= 1'h1;
			hresp_ff <= HRESP_OKAY;
			vel_mode_ff <= nxt_vel_mode;
			trq_mode_ff <= nxt_trq_mode;
			assign_pend_ff <= nxt_assign_pend;
			assign_act_ff <= nxt_assign_act;
			for (int s = 0; s < NUM_SETS; s++) begin
				delay_ff[s] <= nxt_delay[s];
				level_ff[s] <= nxt_level[s];
				hyst_ff[s] <= nxt_hyst[s];
			end
		end
	end

	// thresholds per set
	logic [SET_W:0] up_thr [NUM_SETS];
	logic [SET_W-1:0] dn_thr [NUM_SETS];

	for (genvar s = 0; s < NUM_SETS; s++) begin : g_thr
		logic [SET_W-1:0] hyst_eff;
		always_comb begin
			// see RQ13
			hyst_eff = (hyst_ff[s] > level_ff[s]) ? level_ff[s] : hyst_ff[s];
			up_thr[s] = {1'b0, level_ff[s]} + {1'b0, hyst_eff};
			dn_thr[s] = level_ff[s] - hyst_eff;
		end
	end

	// active mode from control method
	logic [MODE_VEL_W-1:0] act_mode;
	logic act_set;
	logic [CMD_W-1:0] abs_trq, abs_spd, meas;
	logic above, below;

	always_comb begin
		act_set = 1'h0;
		act_mode = SW_FIXED_FIRST;
		unique case (i_ctrl_method)
			CM_VELOCITY: begin
				act_set = 1'(SET_VEL);
				act_mode = vel_mode_ff; // see RQ19, see RQ9
			end
			CM_TORQUE: begin
				act_set = 1'(SET_TRQ);
				act_mode = MODE_VEL_W'(trq_mode_ff); // see RQ14
			end
			CM_POSITION, CM_FULL_CLOSED: begin
				act_mode = SW_FIXED_FIRST;
			end
		endcase
		abs_trq = i_torque_cmd[CMD_W-1] ?
			CMD_W'(-i_torque_cmd) : CMD_W'(i_torque_cmd);
		abs_spd = i_speed_cmd_var[CMD_W-1] ?
			CMD_W'(-i_speed_cmd_var) : CMD_W'(i_speed_cmd_var);
		meas = (act_mode == SW_SPEED_VAR) ? abs_spd : abs_trq;
		above = 32'(meas) > 32'(up_thr[act_set]); // see RQ5, see RQ7
		below = 32'(meas) < 32'(dn_thr[act_set]); // see RQ6, see RQ8
	end

	// free-running 0.1 ms tick
	always_comb begin
		tick = (tick_cnt_ff == TICK_CNT_W'(TICK_CYCLES - 1));
		nxt_tick_cnt = tick ? '0 : TICK_CNT_W'(tick_cnt_ff + 1'b1);
	end

	// gain set state
	always_comb begin
		nxt_state = state_ff;
		nxt_dly_cnt = dly_cnt_ff;
		unique case (act_mode)
			SW_FIXED_FIRST: begin
				nxt_state = GS_FIRST; // see RQ1
				nxt_dly_cnt = '0;
			end
			SW_FIXED_SECOND: begin
				nxt_state = GS_SECOND; // see RQ2
				nxt_dly_cnt = '0;
			end
			SW_INPUT: begin
				// see RQ3, see RQ4
				nxt_state = (assign_act_ff && !gin_sync_ff) ?
					GS_SECOND : GS_FIRST;
				nxt_dly_cnt = '0;
			end
			SW_TORQUE, SW_SPEED_VAR: begin
				if (state_ff == GS_FIRST) begin
					nxt_dly_cnt = '0;
					if (above) begin
						nxt_state = GS_SECOND; // see RQ5, see RQ7
					end
				end else if (!below) begin
					nxt_dly_cnt = '0; // see RQ20
				end else if (SET_W'(dly_cnt_ff) >= delay_ff[act_set]) begin
					nxt_state = GS_FIRST; // see RQ6, see RQ8, see RQ20
					nxt_dly_cnt = '0;
				end else if (tick) begin
					nxt_dly_cnt = DELAY_W'(dly_cnt_ff + 1'b1); // see RQ10
				end
			end
			default: begin
				nxt_state = GS_FIRST;
				nxt_dly_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_ff <= GS_FIRST;
			dly_cnt_ff <= '0;
			tick_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			dly_cnt_ff <= nxt_dly_cnt;
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	assign o_second_gain_set = state_ff;
	assign o_hrdata = hrdata_ff;
	assign o_hreadyout = hready_ff;
	assign o_hresp = hresp_ff;

endmodule

`default_nettype wire

// ---- tb/gain_sel_chk.sv ----
/* checker for the gain set selector, bound to its top-level ports.
 * assumes i_hready is fed from o_hreadyout and whole-word writes. */
`timescale 1ns/1ps
`default_nettype none
module gain_sel_chk (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// bus
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	// selection
	input wire gain_sel_pkg::ctrl_method_t i_ctrl_method,
	input wire logic o_second_gain_set
);
	import gain_sel_pkg::*;
	logic wr_ph_ff;
	logic nxt_wr_ph;
	logic [5:0] mode_ff;
	logic [5:0] nxt_mode;
	// shadow copy of the mode register
	always_comb begin
		nxt_wr_ph = i_hsel && i_hready && i_htrans[1] && i_hwrite;
		nxt_wr_ph = nxt_wr_ph && i_haddr == 32'h0;
		nxt_mode = wr_ph_ff ? i_hwdata[5:0] : mode_ff;
	end
	always_ff @(posedge i_ref_clk) begin
		wr_ph_ff <= i_srst ? 1'b0 : nxt_wr_ph;
		mode_ff <= i_srst ? 6'h00 : nxt_mode;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	AST_RST_FIRST: assert property (disable iff (1'b0)
		i_srst |=> !o_second_gain_set && o_hreadyout && !o_hresp)
		else $error("gain or bus status wrong after reset");
	AST_VEL_FIRST: assert property (
		mode_ff[2:0] == 3'h0 && i_ctrl_method == CM_VELOCITY
		|=> !o_second_gain_set) else $error("velocity mode 0 not first");
	AST_VEL_SECOND: assert property (
		mode_ff[2:0] == 3'h1 && i_ctrl_method == CM_VELOCITY
		|=> o_second_gain_set) else $error("velocity mode 1 not second");
	AST_TRQ_FIRST: assert property (
		mode_ff[5:4] == 2'h0 && i_ctrl_method == CM_TORQUE
		|=> !o_second_gain_set) else $error("torque mode 0 not first");
	AST_TRQ_SECOND: assert property (
		mode_ff[5:4] == 2'h1 && i_ctrl_method == CM_TORQUE
		|=> o_second_gain_set) else $error("torque mode 1 not second");
	AST_OTHER_FIRST: assert property (
		i_ctrl_method inside {CM_POSITION, CM_FULL_CLOSED}
		|=> !o_second_gain_set) else $error("second set outside control");
	AST_VEL5_FIRST: assert property (
		mode_ff[2:0] == 3'h5 && i_ctrl_method == CM_VELOCITY
		|=> !o_second_gain_set) else $error("velocity mode 5 not first");
	AST_RISE_CAUSE: assert property ($rose(o_second_gain_set)
		|-> $past(i_ctrl_method) inside {CM_VELOCITY, CM_TORQUE})
		else $error("second set raised outside control");
	COV_TRQ: cover property (mode_ff[5:4] == 2'h3 && o_second_gain_set);
	COV_RETURN: cover property ($fell(o_second_gain_set));
	COV_PIN: cover property (mode_ff[2:0] == 3'h2 && o_second_gain_set);
endmodule
bind servo_gain_set_selector gain_sel_chk u_chk (
	.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel),
	.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
	.i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp), .i_ctrl_method(i_ctrl_method),
	.o_second_gain_set(o_second_gain_set)
);
`default_nettype wire

// ---- tb/gain_pin_host.sv ----
/* host side of the gain-select pin: open contact or switch to the
 * common return. assumes a pull-up on the pin, so open reads high. */
`timescale 1ns/1ps
`default_nettype none
module gain_pin_host (
	// control from the bench
	input wire logic i_ref_clk,
	input wire logic i_tie,
	// pin
	output logic o_gain_sel_n
);
	initial o_gain_sel_n = 1'b1;
	// contact moves off the clock edge, like a real switch
	always @(posedge i_ref_clk) begin
		o_gain_sel_n <= #7 !i_tie;
	end
endmodule
`default_nettype wire

// ---- tb/servo_gain_set_selector_tb.sv ----
/* self-checking bench for the gain set selector: bus tasks, pin host,
 * fixed, pin and threshold modes. assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module servo_gain_set_selector_tb;
	import gain_sel_pkg::*;
	localparam int W = 17;
	logic clk, srst, hsel, hwrite, tie, pwr;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata;
	wire logic [31:0] hrdata;
	wire logic hrdy, hresp, second, pin_n;
	ctrl_method_t meth;
	logic signed [W-1:0] trq, spd;
	int err_count, checks, cycles, lv, hy;
	servo_gain_set_selector #(.CMD_W(W)) dut (
		.i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp), .i_gain_sel_n(pin_n),
		.i_ctrl_method(meth), .i_torque_cmd(trq), .i_speed_cmd_var(spd),
		.i_ctrl_power_on(pwr), .o_second_gain_set(second));
	gain_pin_host host (.i_ref_clk(clk), .i_tie(tie), .o_gain_sel_n(pin_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic int heff(input int l, h);
		return h > l ? l : h;
	endfunction
	task automatic bus(input logic [31:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rdc(input string n, input logic [31:0] a, e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(n, q, e);
	endtask
	task automatic expo(input logic e);
		cyc(5);
		chk("gain set", {31'h0, second}, {31'h0, e});
	endtask
	initial begin
		{hsel, hwrite, tie, pwr, htrans, haddr, hwdata} = '0;
		meth = CM_VELOCITY;
		{trq, spd} = '0;
		srst = 1'b1;
		void'($urandom(1968));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a <= 28; a += 4) begin
			rdc("reset value", 32'(a), 32'h0);
		end
		// status: first set, pin open (high), velocity method
		rdc("status", 32'h20, 32'h6);
		// each setting at its ceiling, then one above it
		for (int k = 0; k < 6; k++) begin
			lv = k % 3 ? 20000 : 10000;
			wr(32'(4 + 4 * k), 32'(lv));
			wr(32'(4 + 4 * k), 32'(lv + 1));
			rdc("setting", 32'(4 + 4 * k), 32'(lv));
		end
		wr(32'h100, 32'h5);
		rdc("unmapped", 32'h100, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(32'h0, k < 2 ? 32'(k) : 32'(k - 2) << 4);
			meth <= k < 2 ? CM_VELOCITY : CM_TORQUE;
			expo(1'(k % 2));
		end
		wr(32'h0, 32'h15);
		meth <= CM_VELOCITY;
		expo(1'b0);
		meth <= CM_POSITION;
		expo(1'b0);
		meth <= CM_TORQUE;
		expo(1'b1);
		meth <= CM_FULL_CLOSED;
		expo(1'b0);
		// pin assignment waits for control power-up
		wr(32'h1C, 32'h1);
		rdc("assign", 32'h1C, 32'h1);
		wr(32'h0, 32'h2);
		meth <= CM_VELOCITY;
		tie <= 1'b1;
		expo(1'b0);
		pwr <= 1'b1;
		cyc(1);
		pwr <= 1'b0;
		rdc("assign", 32'h1C, 32'h3);
		expo(1'b1);
		tie <= 1'b0;
		expo(1'b0);
		// hysteresis above level is clipped to the level
		wr(32'h10, 32'h0);
		wr(32'h14, 32'h32);
		wr(32'h18, 32'h50);
		wr(32'h0, 32'h30);
		meth <= CM_TORQUE;
		trq <= W'(50 + heff(50, 80));
		expo(1'b0);
		trq <= W'(-(51 + heff(50, 80)));
		expo(1'b1);
		trq <= '0;
		expo(1'b1);
		lv = $urandom_range(4099, 100);
		hy = $urandom_range(99, 0);
		wr(32'h10, 32'h3);
		wr(32'h14, 32'(lv));
		wr(32'h18, 32'(hy));
		cyc(7000);
		chk("held", {31'h0, second}, 32'h1);
		trq <= W'(lv);
		cyc(1);
		trq <= '0;
		cyc(7000);
		chk("restart", {31'h0, second}, 32'h1);
		for (int n = 0; n < 13000 && second !== 1'b0; n++) @(posedge clk);
		chk("return", {31'h0, second}, 32'h0);
		trq <= W'(-(lv + heff(lv, hy)));
		expo(1'b0);
		trq <= W'(lv + heff(lv, hy) + 1);
		expo(1'b1);
		// velocity mode 4 on speed-command variation
		wr(32'h4, 32'h0);
		wr(32'h8, 32'(lv));
		wr(32'hC, 32'(hy));
		wr(32'h0, 32'h4);
		meth <= CM_VELOCITY;
		spd <= W'(-(lv + heff(lv, hy) + 1));
		expo(1'b1);
		meth <= CM_POSITION;
		expo(1'b0);
		meth <= CM_VELOCITY;
		expo(1'b1);
		spd <= W'(lv - heff(lv, hy) - 1);
		expo(1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
